// File: mul_div_sat_datapath.sv
// Purpose: Multiply, long multiply, divide and saturate datapath behind an APB slave.
// Assumes: One clock; operands and control are loaded by software before a start.
// Notes: Division by a nonzero divisor takes 32 cycles with busy set; all other operations finish in one.
//
// What this block does
// RULE1: product_op writes low 32 product bits.
// RULE2: product_plus_op adds addend to product.
// RULE3: product_minus_op subtracts product from addend.
// RULE4: one unsigned low-word multiplier serves both signs.
// RULE5: omitted destination also writes first operand.
// RULE6: flag-setting product_op updates negative and zero.
// RULE7: flag-setting form needs low registers, no condition.
// RULE8: unsigned wide product fills high and low.
// RULE9: unsigned wide accumulate adds into high:low.
// RULE10: signed wide product fills high and low.
// RULE11: signed wide accumulate adds into high:low.
// RULE12: long operations leave all flags unchanged.
// RULE13: high and low word registers must differ.
// RULE14: signed quotient of first by divisor.
// RULE15: unsigned quotient of first by divisor.
// RULE16: inexact quotients truncate towards zero.
// RULE17: divisions leave all flags unchanged.
// RULE18: signed clamp to n bits, n 1..32.
// RULE19: unsigned clamp to 0..2^n-1, n 0..31.
// RULE20: optional arithmetic right or left pre-shift.
// RULE21: clamping sets sticky flag, nothing else.
// RULE22: sticky flag cleared only by status write.
// RULE23: zero divisor gives zero quotient, no flags.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "mul_div_sat_defines.svh"

module mul_div_sat_datapath (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	logic        [31:0] firstOp_q;
	logic        [31:0] secondOp_q;
	logic        [31:0] addend_q;
	logic        [`CTRL_WIDTH-1:0] ctrl_q;
	logic        [31:0] prodLow_q;
	logic        [31:0] prodHigh_q;
	logic               neg_q;
	logic               zero_q;
	logic               carry_q;
	logic               ovf_q;
	logic               sticky_q;
	mul_div_sat_pkg::state_t state_q;
	logic        [32:0] divRem_q;
	logic        [31:0] divQuo_q;
	logic        [31:0] divDen_q;
	logic        [5:0]  divCnt_q;
	logic               divNeg_q;
	logic               divOmit_q;

	logic               access;
	logic               wrEn;
	logic               startEn;
	logic               statusWr;
	mul_div_sat_pkg::op_t opSel;
	logic               destOmit;
	logic        [63:0] prodU;
	logic        [63:0] prodS;
	logic        [31:0] lowProd;
	logic        [31:0] plusRes;
	logic        [31:0] minusRes;
	logic        [63:0] accU;
	logic        [63:0] accS;
	logic        [31:0] shifted;
	logic        [32:0] sClamp;
	logic        [32:0] uClamp;
	logic        [31:0] absNum;
	logic        [31:0] absDen;
	logic        [32:0] remShift;
	logic        [32:0] remSub;
	logic        [31:0] quoNext;
	logic        [31:0] quoFinal;
	logic               divLast;
	logic               clampOp;
	logic               satEvent;

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr == `ADDR_FIRST_OPERAND) || (addr == `ADDR_SECOND_OPERAND) ||
			(addr == `ADDR_ADDEND_REG) || (addr == `ADDR_CONTROL) ||
			(addr == `ADDR_START) || (addr == `ADDR_PRODUCT_LOW) ||
			(addr == `ADDR_PRODUCT_HIGH) || (addr == `ADDR_STATUS_WORD);
	endfunction : isMapped

	// Returns the saturation flag on top of the clamped word.
	function automatic logic [32:0] clampSigned(input logic [31:0] val, input logic [5:0] n);
		logic signed [33:0] v;
		logic signed [33:0] hi;
		logic signed [33:0] lo;
		v  = 34'(signed'(val));
		hi = (34'sh1 <<< (n - 6'h01)) - 34'sh1;
		lo = -(34'sh1 <<< (n - 6'h01));
		if (v > hi)
			clampSigned = {1'b1, hi[31:0]};
		else if (v < lo)
			clampSigned = {1'b1, lo[31:0]};
		else
			clampSigned = {1'b0, val};
	endfunction : clampSigned

	function automatic logic [32:0] clampUnsigned(input logic [31:0] val, input logic [5:0] n);
		logic signed [33:0] v;
		logic signed [33:0] hi;
		v  = 34'(signed'(val));
		hi = (34'sh1 <<< n) - 34'sh1;
		if (v < 34'sh0)
			clampUnsigned = {1'b1, 32'h00000000};
		else if (v > hi)
			clampUnsigned = {1'b1, hi[31:0]};
		else
			clampUnsigned = {1'b0, val};
	endfunction : clampUnsigned

	assign access   = psel & penable & pready;
	assign wrEn     = access & pwrite;
	assign statusWr = wrEn && (paddr == `ADDR_STATUS_WORD);
	assign startEn  = wrEn && (paddr == `ADDR_START) && pwdata[`START_BIT]
		&& (state_q == mul_div_sat_pkg::ST_IDLE);
	assign opSel    = mul_div_sat_pkg::op_t'(ctrl_q[`CTRL_OP_MSB:`CTRL_OP_LSB]);
	assign destOmit = ctrl_q[`CTRL_DEST_OMIT];

	assign lowProd  = 32'(firstOp_q * secondOp_q); // see RULE4
	assign plusRes  = lowProd + addend_q; // see RULE2
	assign minusRes = addend_q - lowProd; // see RULE3
	assign prodU    = {32'h00000000, firstOp_q} * {32'h00000000, secondOp_q}; // see RULE8
	assign prodS    = 64'($signed({{32{firstOp_q[31]}}, firstOp_q})
		* $signed({{32{secondOp_q[31]}}, secondOp_q})); // see RULE10
	assign accU     = {prodHigh_q, prodLow_q} + prodU; // see RULE9
	assign accS     = {prodHigh_q, prodLow_q} + prodS; // see RULE11

	// The pre-shift applies to the second operand before either clamp.
	assign shifted  = ctrl_q[`CTRL_SHIFT_RIGHT]
		? 32'($signed(secondOp_q) >>> ctrl_q[`CTRL_SHIFT_MSB:`CTRL_SHIFT_LSB])
		: secondOp_q << ctrl_q[`CTRL_SHIFT_MSB:`CTRL_SHIFT_LSB]; // see RULE20
	assign sClamp   = clampSigned(shifted, ctrl_q[`CTRL_SATN_MSB:`CTRL_SATN_LSB]); // see RULE18
	assign uClamp   = clampUnsigned(shifted, ctrl_q[`CTRL_SATN_MSB:`CTRL_SATN_LSB]); // see RULE19
	assign clampOp  = (opSel == mul_div_sat_pkg::OP_SCLAMP) || (opSel == mul_div_sat_pkg::OP_UCLAMP);
	assign satEvent = startEn && ((opSel == mul_div_sat_pkg::OP_SCLAMP) ? sClamp[32]
		: (opSel == mul_div_sat_pkg::OP_UCLAMP) && uClamp[32]);

	// Signed division runs on magnitudes and fixes the sign at the end.
	assign absNum   = (opSel == mul_div_sat_pkg::OP_SQUOTIENT && firstOp_q[31])
		? 32'h00000000 - firstOp_q : firstOp_q; // see RULE14
	assign absDen   = (opSel == mul_div_sat_pkg::OP_SQUOTIENT && secondOp_q[31])
		? 32'h00000000 - secondOp_q : secondOp_q;
	assign remShift = {divRem_q[31:0], divQuo_q[31]};
	assign remSub   = remShift - {1'b0, divDen_q};
	assign quoNext  = {divQuo_q[30:0], ~remSub[32]}; // see RULE15
	assign divLast  = (state_q == mul_div_sat_pkg::ST_DIVIDE) && (divCnt_q == `DIV_STEPS - 6'h01);
	// Negating the magnitude quotient truncates towards zero, never floors.
	assign quoFinal = divNeg_q ? 32'h00000000 - quoNext : quoNext; // see RULE16

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `RESET_WORD;
		end
		else
		begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~isMapped(paddr);
			if (psel & ~penable & ~pready & ~pwrite)
			begin
				case (paddr)
					`ADDR_FIRST_OPERAND:  prdata <= firstOp_q;
					`ADDR_SECOND_OPERAND: prdata <= secondOp_q;
					`ADDR_ADDEND_REG:     prdata <= addend_q;
					`ADDR_CONTROL:        prdata <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
					`ADDR_PRODUCT_LOW:    prdata <= prodLow_q;
					`ADDR_PRODUCT_HIGH:   prdata <= prodHigh_q;
					`ADDR_STATUS_WORD:    prdata <= {neg_q, zero_q, carry_q, ovf_q, sticky_q, 26'h0,
						state_q == mul_div_sat_pkg::ST_DIVIDE}; // see RULE22
					default:              prdata <= `RESET_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			secondOp_q <= `RESET_WORD;
			addend_q   <= `RESET_WORD;
			ctrl_q     <= `RESET_CTRL;
		end
		else if (wrEn && state_q == mul_div_sat_pkg::ST_IDLE)
		begin
			case (paddr)
				`ADDR_SECOND_OPERAND: secondOp_q <= pwdata;
				`ADDR_ADDEND_REG:     addend_q   <= pwdata;
				`ADDR_CONTROL:        ctrl_q     <= pwdata[`CTRL_WIDTH-1:0];
				default:              ctrl_q     <= ctrl_q;
			endcase
		end
	end

	// First operand doubles as destination of plain products and divisions when the destination is omitted.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			firstOp_q <= `RESET_WORD;
		else if (startEn && destOmit && opSel == mul_div_sat_pkg::OP_PRODUCT)
			firstOp_q <= lowProd; // see RULE5
		else if (startEn && destOmit && secondOp_q == 32'h00000000 &&
			(opSel == mul_div_sat_pkg::OP_SQUOTIENT || opSel == mul_div_sat_pkg::OP_UQUOTIENT))
			firstOp_q <= 32'h00000000; // see RULE5
		else if (divLast && divOmit_q)
			firstOp_q <= quoFinal; // see RULE5
		else if (wrEn && paddr == `ADDR_FIRST_OPERAND && state_q == mul_div_sat_pkg::ST_IDLE)
			firstOp_q <= pwdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prodLow_q  <= `RESET_WORD;
			prodHigh_q <= `RESET_WORD;
		end
		else if (startEn)
		begin
			case (opSel)
				mul_div_sat_pkg::OP_PRODUCT:       prodLow_q <= lowProd; // see RULE1
				mul_div_sat_pkg::OP_PRODUCT_PLUS:  prodLow_q <= plusRes; // see RULE2
				mul_div_sat_pkg::OP_PRODUCT_MINUS: prodLow_q <= minusRes; // see RULE3
				mul_div_sat_pkg::OP_UWIDE_PRODUCT: {prodHigh_q, prodLow_q} <= prodU; // see RULE8
				mul_div_sat_pkg::OP_UWIDE_ACCUM:   {prodHigh_q, prodLow_q} <= accU; // see RULE9
				mul_div_sat_pkg::OP_SWIDE_PRODUCT: {prodHigh_q, prodLow_q} <= prodS; // see RULE10
				mul_div_sat_pkg::OP_SWIDE_ACCUM:   {prodHigh_q, prodLow_q} <= accS; // see RULE11
				mul_div_sat_pkg::OP_SQUOTIENT,
				mul_div_sat_pkg::OP_UQUOTIENT:
				begin
					if (secondOp_q == 32'h00000000)
						prodLow_q <= 32'h00000000; // see RULE23
				end
				mul_div_sat_pkg::OP_SCLAMP:        prodLow_q <= sClamp[31:0]; // see RULE18
				mul_div_sat_pkg::OP_UCLAMP:        prodLow_q <= uClamp[31:0]; // see RULE19
				default:                           prodLow_q <= prodLow_q;
			endcase
		end
		else if (divLast)
			prodLow_q <= quoFinal; // see RULE14
		else if (wrEn && state_q == mul_div_sat_pkg::ST_IDLE && paddr == `ADDR_PRODUCT_LOW)
			prodLow_q <= pwdata;
		else if (wrEn && state_q == mul_div_sat_pkg::ST_IDLE && paddr == `ADDR_PRODUCT_HIGH)
			prodHigh_q <= pwdata;
	end

	// Only the flag-setting plain product and a status write touch negative and zero.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			neg_q   <= 1'b0;
			zero_q  <= 1'b0;
			carry_q <= 1'b0;
			ovf_q   <= 1'b0;
		end
		else if (startEn && opSel == mul_div_sat_pkg::OP_PRODUCT && ctrl_q[`CTRL_SET_FLAGS])
		begin
			neg_q  <= lowProd[31]; // see RULE6
			zero_q <= (lowProd == 32'h00000000); // see RULE6
		end
		else if (statusWr)
		begin
			neg_q   <= pwdata[`STAT_NEG];
			zero_q  <= pwdata[`STAT_ZERO];
			carry_q <= pwdata[`STAT_CARRY]; // see RULE12 RULE17
			ovf_q   <= pwdata[`STAT_OVF];
		end
	end

	// A saturating clamp in the same cycle as a clearing status write keeps the flag set.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sticky_q <= 1'b0;
		else if (satEvent)
			sticky_q <= 1'b1; // see RULE21
		else if (statusWr)
			sticky_q <= pwdata[`STAT_STICKY]; // see RULE22
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= mul_div_sat_pkg::ST_IDLE;
			divRem_q  <= 33'h000000000;
			divQuo_q  <= `RESET_WORD;
			divDen_q  <= `RESET_WORD;
			divCnt_q  <= 6'h00;
			divNeg_q  <= 1'b0;
			divOmit_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				mul_div_sat_pkg::ST_IDLE:
				begin
					if (startEn && secondOp_q != 32'h00000000 &&
						(opSel == mul_div_sat_pkg::OP_SQUOTIENT ||
						opSel == mul_div_sat_pkg::OP_UQUOTIENT))
					begin
						state_q   <= mul_div_sat_pkg::ST_DIVIDE;
						divRem_q  <= 33'h000000000;
						divQuo_q  <= absNum;
						divDen_q  <= absDen;
						divCnt_q  <= 6'h00;
						divNeg_q  <= (opSel == mul_div_sat_pkg::OP_SQUOTIENT) &&
							(firstOp_q[31] ^ secondOp_q[31]); // see RULE16
						divOmit_q <= destOmit;
					end
				end
				mul_div_sat_pkg::ST_DIVIDE:
				begin
					divRem_q <= remSub[32] ? remShift : remSub;
					divQuo_q <= quoNext;
					divCnt_q <= divCnt_q + 6'h01;
					if (divLast)
						state_q <= mul_div_sat_pkg::ST_IDLE;
				end
				default: state_q <= mul_div_sat_pkg::ST_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence divStart;
		startEn && state_q == mul_div_sat_pkg::ST_IDLE && secondOp_q != 32'h00000000 &&
			(opSel == mul_div_sat_pkg::OP_SQUOTIENT || opSel == mul_div_sat_pkg::OP_UQUOTIENT);
	endsequence
	sequence divBusy32;
		(state_q == mul_div_sat_pkg::ST_DIVIDE)[*8] ##1 (state_q == mul_div_sat_pkg::ST_DIVIDE)[*8]
			##1 (state_q == mul_div_sat_pkg::ST_DIVIDE)[*8] ##1
			(state_q == mul_div_sat_pkg::ST_DIVIDE)[*8] ##1 (state_q == mul_div_sat_pkg::ST_IDLE);
	endsequence

	a_mul_low_word: assert property (startEn && opSel == mul_div_sat_pkg::OP_PRODUCT // see RULE1
		|=> prodLow_q == 32'($past(firstOp_q) * $past(secondOp_q)))
		else $error("product low word wrong");
	a_mla_sum: assert property (startEn && opSel == mul_div_sat_pkg::OP_PRODUCT_PLUS // see RULE2
		|=> prodLow_q == 32'($past(firstOp_q) * $past(secondOp_q) + $past(addend_q)))
		else $error("multiply-accumulate result wrong");
	a_mls_difference: assert property (startEn && opSel == mul_div_sat_pkg::OP_PRODUCT_MINUS // see RULE3
		|=> prodLow_q == 32'($past(addend_q) - $past(firstOp_q) * $past(secondOp_q)))
		else $error("multiply-subtract result wrong");
	a_wide_unsigned: assert property (startEn && opSel == mul_div_sat_pkg::OP_UWIDE_PRODUCT // see RULE8
		|=> {prodHigh_q, prodLow_q} == {32'h0, $past(firstOp_q)} * {32'h0, $past(secondOp_q)})
		else $error("unsigned wide product wrong");
	a_div_duration: assert property (divStart |=> divBusy32) // see RULE15
		else $error("division did not take 32 cycles");
	a_div_zero: assert property (startEn && secondOp_q == 32'h00000000 && // see RULE23
		opSel == mul_div_sat_pkg::OP_UQUOTIENT |=> prodLow_q == 32'h00000000 &&
		state_q == mul_div_sat_pkg::ST_IDLE)
		else $error("zero divisor did not give zero");
	a_carry_stable: assert property (!statusWr |=> $stable(carry_q) && $stable(ovf_q)) // see RULE12
		else $error("carry or overflow changed without status write");
	a_flags_quiet: assert property (!statusWr && !(startEn && opSel == // see RULE17
		mul_div_sat_pkg::OP_PRODUCT) |=> $stable(neg_q) && $stable(zero_q))
		else $error("negative or zero flag changed by wrong operation");
	// Saturation means the clamped word differs from the shifted source.
	a_sticky_set: assert property (startEn && clampOp && // see RULE21
		shifted != (opSel == mul_div_sat_pkg::OP_SCLAMP ? sClamp[31:0] : uClamp[31:0])
		|=> sticky_q)
		else $error("saturation did not set sticky flag");
	a_sticky_hold: assert property ($fell(sticky_q) |-> $past(statusWr)) // see RULE22
		else $error("sticky flag cleared without status write");

endmodule : mul_div_sat_datapath

// File: mul_div_sat_datapath_bench.sv
// Purpose: Self-checking bench of the arithmetic datapath.
// Assumes: Registers and operation codes as the defines header and package give them.
// Notes: Every row preloads operands and accumulator, and flags when asked, starts, polls busy, then reads back.
`timescale 1ns/1ns
`include "mul_div_sat_defines.svh"

`define CK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module mul_div_sat_datapath_bench;
	typedef struct {
		logic [17:0] c;
		logic [31:0] a, b, ad, h;
		logic [4:0]  si;
		logic [31:0] lo, hi;
		logic [4:0]  so;
	} row_t;

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          n_checks = 0;
	row_t        t;

	// Flag-setting products are issued unconditionally
	row_t rows[] = '{
		'{18'h00000, 32'h10003, 32'h20005, 32'h0, 32'h0, 5'h1E, 32'hB000F, 32'h0, 5'h1E},
		'{18'h00010, 32'hFFFFFFFF, 32'h2, 32'h0, 32'h0, 5'h06, 32'hFFFFFFFE, 32'h0, 5'h16},
		'{18'h00010, 32'h10000, 32'h10000, 32'h0, 32'h0, 5'h10, 32'h0, 32'h0, 5'h08},
		'{18'h00020, 32'h7, 32'h6, 32'h0, 32'h0, 5'h1E, 32'h2A, 32'h0, 5'h1E},
		'{18'h00001, 32'h3, 32'hFFFFFFFF, 32'hA, 32'h0, 5'h1E, 32'h7, 32'h0, 5'h1E},
		'{18'h00002, 32'h2, 32'h3, 32'h5, 32'h0, 5'h1E, 32'hFFFFFFFF, 32'h0, 5'h1E},
		'{18'h00003, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 5'h1E, 32'h1, 32'hFFFFFFFE, 5'h1E},
		'{18'h00004, 32'h10001, 32'h10001, 32'hFFFFFFFF, 32'h1, 5'h1E, 32'h20000, 32'h3, 5'h1E},
		'{18'h00005, 32'hFFFFFFFE, 32'h3, 32'h0, 32'h0, 5'h1E, 32'hFFFFFFFA, 32'hFFFFFFFF, 5'h1E},
		'{18'h00006, 32'hFFFFFFFE, 32'h3, 32'h10, 32'h0, 5'h1E, 32'hA, 32'h0, 5'h1E},
		'{18'h00007, 32'hFFFFFFF9, 32'h2, 32'h0, 32'h0, 5'h1E, 32'hFFFFFFFD, 32'h0, 5'h1E},
		'{18'h00008, 32'hFFFFFFF9, 32'h2, 32'h0, 32'h0, 5'h1E, 32'h7FFFFFFC, 32'h0, 5'h1E},
		'{18'h00027, 32'h64, 32'hFFFFFFF9, 32'h0, 32'h0, 5'h1E, 32'hFFFFFFF2, 32'h0, 5'h1E},
		'{18'h00008, 32'h5, 32'h0, 32'h0, 32'h0, 5'h1E, 32'h0, 32'h0, 5'h1E},
		'{18'h10209, 32'h0, 32'h1000, 32'h0, 32'h0, 5'h1E, 32'h7FFF, 32'h0, 5'h1F},
		'{18'h10009, 32'h0, 32'hFFFF0000, 32'h0, 32'h0, 5'h1E, 32'hFFFF8000, 32'h0, 5'h1F},
		'{18'h080C9, 32'h0, 32'hFFFFFF00, 32'h0, 32'h0, 5'h1E, 32'hFFFFFF80, 32'h0, 5'h1E},
		'{18'h20009, 32'h0, 32'h80000000, 32'h0, 32'h0, 5'h1E, 32'h80000000, 32'h0, 5'h1E},
		'{18'h01009, 32'h0, 32'h5, 32'h0, 32'h0, 5'h00, 32'h0, 32'h0, 5'h01},
		'{18'h0700A, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 5'h1E, 32'h0, 32'h0, 5'h1F},
		'{18'h0000A, 32'h0, 32'h1, 32'h0, 32'h0, 5'h06, 32'h0, 32'h0, 5'h07},
		'{18'h1F00A, 32'h0, 32'h7FFFFFFF, 32'h0, 32'h0, 5'h1E, 32'h7FFFFFFF, 32'h0, 5'h1E},
		'{18'h0840A, 32'h0, 32'h1, 32'h0, 32'h0, 5'h1E, 32'hFF, 32'h0, 5'h1F},
		'{18'h08FCA, 32'h0, 32'h80000000, 32'h0, 32'h0, 5'h1E, 32'h0, 32'h0, 5'h1F}
	};

	mul_div_sat_datapath dut_u (
		.clk     (clk),
		.rst_n   (rst_n),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	op_source_model src_u (
		.clk     (clk),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
	end

	always #25 clk = ~clk;

	task automatic end_of_test;
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		src_u.xfer(1'b1, a, d, rd, er);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		src_u.xfer(1'b0, a, 32'h0, rd, er);
	endtask : rdr

	task automatic run(input row_t r, input logic pre);
		int k;
		wr(`ADDR_FIRST_OPERAND, r.a);
		wr(`ADDR_SECOND_OPERAND, r.b);
		wr(`ADDR_ADDEND_REG, r.ad);
		wr(`ADDR_PRODUCT_LOW, r.ad);
		wr(`ADDR_PRODUCT_HIGH, r.h);
		if (pre)
			wr(`ADDR_STATUS_WORD, {r.si, 27'h0});
		wr(`ADDR_CONTROL, {14'h0, r.c});
		wr(`ADDR_START, 32'h1);
		for (k = 0; k < 64; k++)
		begin
			rdr(`ADDR_STATUS_WORD);
			if (rd[0] === 1'b0)
				break;
		end
		`CK(rd, {r.so, 27'h0})
		rdr(`ADDR_PRODUCT_LOW);
		`CK(rd, r.lo)
		if (r.c[3:0] inside {[4'h3:4'h6]})
		begin
			rdr(`ADDR_PRODUCT_HIGH);
			`CK(rd, r.hi)
		end
		rdr(`ADDR_FIRST_OPERAND);
		`CK(rd, (r.c[5] ? r.lo : r.a))
	endtask : run

	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i])
			run(rows[i], 1'b1);
		// Registers come out of reset cleared and mapped words answer without error.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 8; k++)
		begin
			rdr(8'(k * 4));
			`CK(rd, 32'h0)
			`CK(er, 1'b0)
		end
		wr(8'h20, 32'hFFFFFFFF);
		`CK(er, 1'b1)
		rdr(8'h20);
		`CK(er, 1'b1)
		`CK(rd, 32'h0)
		// Sticky saturation survives a later clamp that does not saturate.
		run(rows[14], 1'b1);
		t = rows[16];
		t.so = 5'h1F;
		run(t, 1'b0);
		wr(`ADDR_STATUS_WORD, 32'h0);
		rdr(`ADDR_STATUS_WORD);
		`CK(rd, 32'h0)
		end_of_test();
	end
endmodule : mul_div_sat_datapath_bench

// File: mul_div_sat_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the arithmetic datapath.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Included by its bare name.
`ifndef MUL_DIV_SAT_DEFINES_SVH
`define MUL_DIV_SAT_DEFINES_SVH

`define ADDR_FIRST_OPERAND  8'h00
`define ADDR_SECOND_OPERAND 8'h04
`define ADDR_ADDEND_REG     8'h08
`define ADDR_CONTROL        8'h0C
`define ADDR_START          8'h10
`define ADDR_PRODUCT_LOW    8'h14
`define ADDR_PRODUCT_HIGH   8'h18
`define ADDR_STATUS_WORD    8'h1C

`define CTRL_OP_LSB      0
`define CTRL_OP_MSB      3
`define CTRL_SET_FLAGS   4
`define CTRL_DEST_OMIT   5
`define CTRL_SHIFT_RIGHT 6
`define CTRL_SHIFT_LSB   7
`define CTRL_SHIFT_MSB   11
`define CTRL_SATN_LSB    12
`define CTRL_SATN_MSB    17
`define CTRL_WIDTH       18

`define STAT_NEG    31
`define STAT_ZERO   30
`define STAT_CARRY  29
`define STAT_OVF    28
`define STAT_STICKY 27
`define STAT_BUSY   0

`define START_BIT   0
`define RESET_WORD  32'h00000000
`define RESET_CTRL  18'h00000
`define DIV_STEPS   6'h20

`endif

// File: mul_div_sat_pkg.sv
// Purpose: Types of the arithmetic datapath.
// Assumes: Nothing beyond the defines header.
// Notes: Operation codes are the values software writes into the control word.
package mul_div_sat_pkg;

	typedef enum logic [3:0] {
		OP_PRODUCT       = 4'h0,
		OP_PRODUCT_PLUS  = 4'h1,
		OP_PRODUCT_MINUS = 4'h2,
		OP_UWIDE_PRODUCT = 4'h3,
		OP_UWIDE_ACCUM   = 4'h4,
		OP_SWIDE_PRODUCT = 4'h5,
		OP_SWIDE_ACCUM   = 4'h6,
		OP_SQUOTIENT     = 4'h7,
		OP_UQUOTIENT     = 4'h8,
		OP_SCLAMP        = 4'h9,
		OP_UCLAMP        = 4'hA
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DIVIDE = 2'b01
	} state_t;

endpackage : mul_div_sat_pkg

// File: op_source_model.sv
// Purpose: Instruction source model that issues operand, control and start words over APB.
// Assumes: Each transfer is entered right after a rising clock edge.
// Notes: Released address and data lines carry the inverse of their last value.
`timescale 1ns/1ns

module op_source_model (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'hFFFFFFFF;
	end

	// One transfer, then one idle cycle so that the next request never lands in the same step.
	task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 32)
		begin
			@(posedge clk);
			n++;
		end
		rd = (pready === 1'b1) ? prdata : 32'hX;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~ad;
		pwdata <= ~wd;
		@(posedge clk);
	endtask : xfer
endmodule : op_source_model
